/* File: src/csb_consts.svh */
// constants for the conditional skip and branch unit
// How it works
// [RULE1] register bit one skips next instruction
// [RULE2] io bit clear skips, 1/2/3 cycles
// [RULE3] io bit set skips, 1/2/3 cycles
// [RULE4] flag set branches pc+k+1, 1/2 cycles
// [RULE5] flag clear branches pc+k+1, 1/2 cycles
// [RULE6] zero flag one takes relative branch
// [RULE7] zero flag zero branches, 1/2 cycles
// [RULE8] flags untouched, eight flags, signed displacement
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH

// ==========================================================
// operand layout
`define CSB_DATA_W 8
`define CSB_SEL_W 3
`define CSB_DISP_W 7
`define CSB_ZERO_FLAG_BIT 3'h1

// ==========================================================
// cycle counts
`define CSB_CYC_SEQ 2'h1
`define CSB_CYC_BRANCH 2'h2
`define CSB_CYC_SKIP1 2'h2
`define CSB_CYC_SKIP2 2'h3

// ==========================================================
// reset values
`define CSB_RST_PC 16'h0000

`endif

/* File: src/csb_pkg.sv */
// types for the conditional skip and branch unit
`include "csb_consts.svh"

package csb_pkg;

    typedef enum logic [2:0]
    {
        skip_if_reg_bit_set,
        skip_if_io_bit_clear,
        skip_if_io_bit_set,
        branch_if_flag_set,
        branch_if_flag_clear,
        branch_if_equal,
        branch_if_not_equal
    } csb_op_e;

    typedef struct packed
    {
        csb_op_e                        op;
        logic [`CSB_SEL_W-1:0]          bit_sel;
        logic [`CSB_DATA_W-1:0]         source_general_register;
        logic [`CSB_DATA_W-1:0]         io_value;
        logic signed [`CSB_DISP_W-1:0]  disp;
        logic                           next_two_words;
        logic [15:0]                    pc;
    } csb_req_s;

    typedef struct packed
    {
        logic [15:0] pc;
        logic        taken;
        logic [1:0]  cycles;
    } csb_resp_s;

endpackage

/* File: src/csb_unit.sv */
// conditional skip and relative branch execution unit
`timescale 1ns/1ps
`include "csb_consts.svh"

module csb_unit
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   req_valid,
    input  wire csb_pkg::csb_req_s      req,
    input  wire logic [`CSB_DATA_W-1:0] status_flags_register,
    output logic                        req_ready,
    output logic                        done,
    output csb_pkg::csb_resp_s          resp,
    output logic [`CSB_DATA_W-1:0]      status_flags_out
);

    // ==========================================================
    // decode
    function automatic logic cond_holds
    (
        input csb_pkg::csb_req_s      r,
        input logic [`CSB_DATA_W-1:0] f
    );
        logic res;
        res = 1'b0;
        case (r.op)
            csb_pkg::skip_if_reg_bit_set:
                res = r.source_general_register[r.bit_sel]; // RULE1
            csb_pkg::skip_if_io_bit_clear:
                res = !r.io_value[r.bit_sel]; // RULE2
            csb_pkg::skip_if_io_bit_set:
                res = r.io_value[r.bit_sel]; // RULE3
            csb_pkg::branch_if_flag_set:
                res = f[r.bit_sel]; // RULE4
            csb_pkg::branch_if_flag_clear:
                res = !f[r.bit_sel]; // RULE5
            csb_pkg::branch_if_equal:
                res = f[`CSB_ZERO_FLAG_BIT]; // RULE6
            csb_pkg::branch_if_not_equal:
                res = !f[`CSB_ZERO_FLAG_BIT]; // RULE7
            default:
                res = 1'b0;
        endcase
        return res;
    endfunction

    function automatic logic is_skip(input csb_pkg::csb_op_e op);
        return op == csb_pkg::skip_if_reg_bit_set
            || op == csb_pkg::skip_if_io_bit_clear
            || op == csb_pkg::skip_if_io_bit_set;
    endfunction

    typedef enum logic {csb_idle, csb_wait} csb_state_e;

    csb_state_e         state;
    logic [1:0]         remain;
    logic               take;
    logic [1:0]         next_cycles;
    logic [15:0]        next_pc;
    logic               accept;
    csb_pkg::csb_resp_s held;

    assign accept = req_valid && req_ready;

    always_comb
    begin
        take = cond_holds(req, status_flags_register);
        next_cycles = `CSB_CYC_SEQ;
        next_pc = req.pc + 16'h0001;
        if (take && is_skip(req.op))
        begin
            // skipped word count decides 2 or 3
            next_cycles = req.next_two_words ? `CSB_CYC_SKIP2
                                             : `CSB_CYC_SKIP1; // RULE2 RULE3
            next_pc = req.pc + (req.next_two_words ? 16'h0003
                                                   : 16'h0002); // RULE1
        end
        else if (take)
        begin
            next_cycles = `CSB_CYC_BRANCH; // RULE4 RULE5 RULE6 RULE7
            // signed displacement, sign extended to pc width
            next_pc = req.pc + 16'(signed'(req.disp)) + 16'h0001; // RULE8
        end
    end

    // ==========================================================
    // sequencing
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= csb_idle;
            remain    <= 2'h0;
            req_ready <= 1'b1;
            done      <= 1'b0;
            resp      <= '{pc: `CSB_RST_PC, taken: 1'b0, cycles: 2'h0};
            held      <= '{pc: `CSB_RST_PC, taken: 1'b0, cycles: 2'h0};
        end
        else
        begin
            done <= 1'b0;
            case (state)
                csb_idle:
                    if (accept)
                    begin
                        if (next_cycles == `CSB_CYC_SEQ)
                        begin
                            done <= 1'b1;
                            resp <= '{pc: next_pc, taken: take,
                                      cycles: next_cycles};
                        end
                        else
                        begin
                            // hold the answer until the last cycle
                            held      <= '{pc: next_pc, taken: take,
                                           cycles: next_cycles};
                            remain    <= next_cycles - 2'h1;
                            req_ready <= 1'b0;
                            state     <= csb_wait;
                        end
                    end
                csb_wait:
                    if (remain == 2'h1)
                    begin
                        done      <= 1'b1;
                        resp      <= held;
                        req_ready <= 1'b1;
                        state     <= csb_idle;
                    end
                    else
                        remain <= remain - 2'h1;
                default:
                    state <= csb_idle;
            endcase
        end
    end

    // ==========================================================
    // flags pass through untouched
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            status_flags_out <= '0;
        else
            status_flags_out <= status_flags_register; // RULE8
    end

    // ==========================================================
    // checks
    sequence s_issue_taken;
        req_valid && req_ready && cond_holds(req, status_flags_register);
    endsequence

    sequence s_issue_seq;
        req_valid && req_ready && !cond_holds(req, status_flags_register);
    endsequence

    property p_reg_skip;
        @(posedge sys_clk) disable iff (rst)
        (s_issue_taken and
         (req.op == csb_pkg::skip_if_reg_bit_set && !req.next_two_words))
        |=> !done ##1 (done && resp.pc == $past(req.pc, 2) + 16'h0002);
    endproperty
    a_reg_skip: assert property (p_reg_skip) // RULE1
        else $error("register bit skip wrong");

    property p_io_clear_two;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && req_ready && req.op == csb_pkg::skip_if_io_bit_clear
         && !req.io_value[req.bit_sel] && req.next_two_words)
        |=> !done [*2] ##1 (done && resp.cycles == 2'h3);
    endproperty
    a_io_clear_two: assert property (p_io_clear_two) // RULE2
        else $error("io clear skip cycle count wrong");

    property p_io_set_none;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && req_ready && req.op == csb_pkg::skip_if_io_bit_set
         && !req.io_value[req.bit_sel])
        |=> done && !resp.taken && resp.pc == $past(req.pc) + 16'h0001;
    endproperty
    a_io_set_none: assert property (p_io_set_none) // RULE3
        else $error("io set fall through wrong");

    property p_flag_set;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && req_ready && req.op == csb_pkg::branch_if_flag_set
         && status_flags_register[req.bit_sel])
        |=> !req_ready ##1 (done && resp.taken && req_ready);
    endproperty
    a_flag_set: assert property (p_flag_set) // RULE4
        else $error("flag set branch timing wrong");

    property p_flag_clear;
        @(posedge sys_clk) disable iff (rst)
        (req_valid && req_ready && req.op == csb_pkg::branch_if_flag_clear
         && status_flags_register[req.bit_sel])
        |=> done && !resp.taken;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // RULE5
        else $error("flag clear branch taken wrongly");

    property p_equal;
        @(posedge sys_clk) disable iff (rst)
        (s_issue_taken and (req.op == csb_pkg::branch_if_equal))
        |=> ##1 (done && resp.pc == $past(req.pc, 2)
                 + 16'(signed'($past(req.disp, 2))) + 16'h0001);
    endproperty
    a_equal: assert property (p_equal) // RULE6
        else $error("equal branch target wrong");

    property p_not_equal;
        @(posedge sys_clk) disable iff (rst)
        (s_issue_seq and (req.op == csb_pkg::branch_if_not_equal))
        |=> done && resp.cycles == 2'h1;
    endproperty
    a_not_equal: assert property (p_not_equal) // RULE7
        else $error("not equal fall through wrong");

    property p_flags_kept;
        @(posedge sys_clk) disable iff (rst)
        done |-> status_flags_out == $past(status_flags_register);
    endproperty
    a_flags_kept: assert property (p_flags_kept) // RULE8
        else $error("status flags altered");

endmodule

/* File: tb/conditional_skip_branch_unit_bench.sv */
// self-checking bench for the skip and branch unit
`timescale 1ns/1ps
`include "csb_consts.svh"

module conditional_skip_branch_unit_bench;
    logic               sys_clk;
    logic               rst;
    logic               req_valid;
    csb_pkg::csb_req_s  req;
    logic [7:0]         flags;
    logic               req_ready;
    logic               done;
    csb_pkg::csb_resp_s resp;
    logic [7:0]         flags_out;
    int                 error_cnt;
    int                 checks;
    int                 cyc_cnt;

    csb_unit u_dut
    (
        .sys_clk               (sys_clk),
        .rst                   (rst),
        .req_valid             (req_valid),
        .req                   (req),
        .status_flags_register (flags),
        .req_ready             (req_ready),
        .done                  (done),
        .resp                  (resp),
        .status_flags_out      (flags_out)
    );

    // ==========================================================
    // helpers
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // bench's own reading of the skip and branch rules
    function automatic csb_pkg::csb_resp_s model(csb_pkg::csb_req_s r,
                                                 logic [7:0] f);
        csb_pkg::csb_resp_s e;
        logic               skip;
        skip = r.op < csb_pkg::branch_if_flag_set;
        case (r.op)
            csb_pkg::skip_if_reg_bit_set:
                e.taken = r.source_general_register[r.bit_sel];
            csb_pkg::skip_if_io_bit_clear: e.taken = !r.io_value[r.bit_sel];
            csb_pkg::skip_if_io_bit_set:   e.taken = r.io_value[r.bit_sel];
            csb_pkg::branch_if_flag_set:   e.taken = f[r.bit_sel];
            csb_pkg::branch_if_flag_clear: e.taken = !f[r.bit_sel];
            csb_pkg::branch_if_equal:      e.taken = f[1];
            default:                       e.taken = !f[1];
        endcase
        e.cycles = !e.taken ? 2'h1 : (skip && r.next_two_words) ? 2'h3 : 2'h2;
        if (!e.taken || skip)
            e.pc = r.pc + 16'(e.cycles);
        else
            e.pc = r.pc + {{9{r.disp[6]}}, r.disp} + 16'h0001;
        return e;
    endfunction

    // one request, driven for one cycle, then judged at done
    task automatic run(input csb_pkg::csb_req_s r, input logic [7:0] f);
        csb_pkg::csb_resp_s e;
        int                 n;
        e = model(r, f);
        n = 1;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= r;
        flags <= f;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 4)
        begin
            check(req_ready, 1'b0, "ready while busy");
            @(posedge sys_clk);
            n++;
            #1;
        end
        check(n, e.cycles, "latency");
        check(resp, e, "response");
        check(flags_out, f, "flags altered");
        @(posedge sys_clk);
        #1;
        check(done, 1'b0, "done width");
    endtask

    // ==========================================================
    // scenarios
    task automatic test_skips();
        csb_pkg::csb_req_s r;
        logic [7:0]        one_hot;
        for (int k = 0; k < 3; k++)
            for (int s = 0; s < 8; s += 7)
                for (int v = 0; v < 4; v++)
                begin
                    r = '0;
                    r.op = csb_pkg::csb_op_e'(k);
                    r.bit_sel = 3'(s);
                    one_hot = 8'h01 << s;
                    r.source_general_register = v[0] ? one_hot : ~one_hot;
                    r.io_value = r.source_general_register;
                    r.next_two_words = v[1];
                    r.pc = 16'hfffe;
                    run(r, 8'ha5);
                end
        $display("skip test done");
    endtask

    task automatic test_branches();
        csb_pkg::csb_req_s r;
        logic [7:0]        one_hot;
        for (int k = 3; k < 5; k++)
            for (int s = 0; s < 8; s++)
                for (int v = 0; v < 4; v++)
                begin
                    r = '0;
                    r.op = csb_pkg::csb_op_e'(k);
                    r.bit_sel = 3'(s);
                    r.disp = v[1] ? 7'h40 : 7'h3f;
                    r.pc = 16'h0010;
                    one_hot = 8'h01 << s;
                    run(r, v[0] ? one_hot : ~one_hot);
                end
        $display("flag branch test done");
    endtask

    task automatic test_zero();
        csb_pkg::csb_req_s r;
        for (int k = 5; k < 7; k++)
            for (int v = 0; v < 2; v++)
            begin
                r = '0;
                r.op = csb_pkg::csb_op_e'(k);
                r.bit_sel = 3'h7;
                r.disp = 7'h7b;
                r.pc = 16'h1234;
                run(r, v[0] ? 8'h02 : 8'hfd);
            end
        $display("zero flag test done");
    endtask

    // ==========================================================
    // timeout and main sequence
    always @(posedge sys_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 2000)
        begin
            error_cnt++;
            test_done();
        end
    end

    initial
    begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        flags = 8'h00;
        error_cnt = 0;
        checks = 0;
        cyc_cnt = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check({req_ready, done, resp}, 21'h100000, "reset state");
        test_skips();
        test_branches();
        test_zero();
        test_done();
    end
endmodule
